// ---- shared/lpd_pkg.sv ----
package lpd_pkg;

   // ---------------------------------------------------------------
   // Clock and time base
   // ---------------------------------------------------------------
   localparam int  CLK_FREQ_MHZ  = 125;
   localparam int  CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
   localparam real TIME_BASE_US  = 0.5;
   localparam int  TIME_BASE_NS  = int'(TIME_BASE_US * 1000.0);

   // ---------------------------------------------------------------
   // PWM period and duty coding
   // ---------------------------------------------------------------
   localparam int         NUM_CHANNELS  = 3;
   localparam int         DUTY_W        = 7;
   localparam int         PERIOD_COUNTS = 95;
   localparam logic [6:0] DUTY_FULL     = 7'h5F;
   localparam logic [6:0] DUTY_OFF      = 7'h00;

   // ---------------------------------------------------------------
   // Ramp step timing, counted in time-base ticks
   // ---------------------------------------------------------------
   localparam int RAMP_STEP_MS    = 32;
   localparam int RAMP_STEP_TICKS = (RAMP_STEP_MS * 1000 * 1000) / TIME_BASE_NS;
   localparam int RAMP_CNT_W      = 17;

   // ---------------------------------------------------------------
   // Register map: word indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam int         ADDR_W        = 10;
   localparam logic [7:0] CHAN_A_IDX    = 8'hC6;
   localparam logic [7:0] CHAN_B_IDX    = 8'hC7;
   localparam logic [7:0] CHAN_C_IDX    = 8'hC8;
   localparam logic [7:0] APPLIED_A_IDX = 8'h40;
   localparam logic [7:0] APPLIED_B_IDX = 8'h41;
   localparam logic [7:0] APPLIED_C_IDX = 8'h42;
   localparam logic [7:0] CHAN_IDX    [NUM_CHANNELS] = '{CHAN_A_IDX, CHAN_B_IDX, CHAN_C_IDX};
   localparam logic [7:0] APPLIED_IDX [NUM_CHANNELS] =
      '{APPLIED_A_IDX, APPLIED_B_IDX, APPLIED_C_IDX};

   // Field positions and reset values
   localparam int         RAMP_BIT   = 7;
   localparam int         DUTY_MSB   = 6;
   localparam logic [7:0] CHAN_RESET = 8'h00;

   // Channel drive register layout
   typedef struct packed {
      logic       rampEnable;
      logic [6:0] dutyCode;
   } lpd_chan_cfg_t;

endpackage

// ---- logic/lpd_timebase.sv ----
`timescale 1ns/100ps
module lpd_timebase #(
   parameter int RAMP_TICKS = lpd_pkg::RAMP_STEP_TICKS
) (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   output logic [6:0]      periodCount,
   output logic            periodStart,
   output logic            rampStep
);

   // ---------------------------------------------------------------
   // Fractional time base
   // ---------------------------------------------------------------
   // 0.5 us is 62.5 clocks; an ns accumulator alternates 62 and 63
   // so the long-term rate is exact.
   logic [9:0]                    nsAcc;
   logic [lpd_pkg::RAMP_CNT_W-1:0] rampCnt;
   logic                          baseTick;
   logic [9:0]                    sumNs;
   logic                          lastCount;

   assign sumNs     = nsAcc + 10'(lpd_pkg::CLK_PERIOD_NS);
   assign baseTick  = (sumNs >= 10'(lpd_pkg::TIME_BASE_NS));
   assign lastCount = (periodCount == 7'(lpd_pkg::PERIOD_COUNTS - 1));

   // Accumulate clock time, wrap at one time-base step
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         nsAcc <= 10'h000;
      end else if (baseTick) begin
         nsAcc <= sumNs - 10'(lpd_pkg::TIME_BASE_NS);
      end else begin
         nsAcc <= sumNs;
      end
   end

   // Start pulse on the wrapping tick itself: the new duty loads on the
   // same edge as the count returns to zero, so tick 0 never uses a stale
   // duty (a stale one gave a one-clock pulse on a change to zero).
   assign periodStart = baseTick & lastCount;

   // Period counter 0..94
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         periodCount <= 7'h00;
      end else if (baseTick) begin
         periodCount <= lastCount ? 7'h00 : periodCount + 7'h01;
      end
   end

   // Ramp step pulse every RAMP_TICKS time-base ticks
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rampCnt  <= '0;
         rampStep <= 1'b0;
      end else begin
         rampStep <= 1'b0;
         if (baseTick) begin
            if (rampCnt == lpd_pkg::RAMP_CNT_W'(RAMP_TICKS - 1)) begin
               rampCnt  <= '0;
               rampStep <= 1'b1;
            end else begin
               rampCnt <= rampCnt + 1'b1;
            end
         end
      end
   end

endmodule

// ---- logic/lpd_duty_ramp.sv ----
`timescale 1ns/100ps
module lpd_duty_ramp (
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   input  lpd_pkg::lpd_chan_cfg_t      cfg,
   input  wire logic                   periodStart,
   input  wire logic                   rampStep,
   output logic [6:0]                  applied
);

   // ---------------------------------------------------------------
   // Target and step decision
   // ---------------------------------------------------------------
   // Codes above full are clamped so a ramp stops at full duty
   // instead of stepping through dead codes.
   logic [6:0] target;
   logic       stepPending;
   logic       stepNow;
   logic [6:0] next_applied;

   assign target  = (cfg.dutyCode >= lpd_pkg::DUTY_FULL) ? lpd_pkg::DUTY_FULL
                                                         : cfg.dutyCode;
   assign stepNow = stepPending | rampStep;

   // Pick the next applied duty
   always_comb begin
      next_applied = applied;
      if (!cfg.rampEnable) begin
         next_applied = target;
      end else if (stepNow && applied < target) begin
         next_applied = applied + 7'h01;
      end else if (stepNow && applied > target) begin
         next_applied = applied - 7'h01;
      end
   end

   // Take the change over only at a period boundary
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         applied     <= lpd_pkg::DUTY_OFF;
         stepPending <= 1'b0;
      end else begin
         if (periodStart) begin
            applied <= next_applied;
         end
         // A new step pulse wins over consumption in the same cycle
         stepPending <= rampStep | (stepPending & ~periodStart);
      end
   end

endmodule

// ---- logic/lpd_top.sv ----
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
module lpd_top #(
   parameter int RAMP_TICKS = lpd_pkg::RAMP_STEP_TICKS
) (
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   input  wire logic [lpd_pkg::ADDR_W-1:0] address,
   input  wire logic                       read,
   input  wire logic                       write,
   input  wire logic [31:0]                writedata,
   input  wire logic [3:0]                 byteenable,
   output logic [31:0]                     readdata,
   output logic                            waitrequest,
   output logic [lpd_pkg::NUM_CHANNELS-1:0] ledDrive
);

   localparam int NCH = lpd_pkg::NUM_CHANNELS;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   lpd_pkg::lpd_chan_cfg_t cfgReg [NCH];
   logic [6:0]             applied [NCH];
   logic [31:0]            rdTerm [NCH+1];
   logic [NCH-1:0]         hitCfg;
   logic [NCH-1:0]         hitApplied;
   logic [NCH-1:0]         pinOn;
   logic [7:0]             wordIdx;
   logic                   request;
   logic                   accept;
   logic                   writeAccept;
   logic [6:0]             periodCount;
   logic                   periodStart;
   logic                   rampStep;

   // ---------------------------------------------------------------
   // Shared time base
   // ---------------------------------------------------------------
   // One period counter serves all channels, so their pulses all
   // start together; that keeps the logic small at the cost of a
   // shared inrush edge on the supply.
   lpd_timebase #(
      .RAMP_TICKS (RAMP_TICKS)
   ) u_timebase (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .periodCount (periodCount),
      .periodStart (periodStart),
      .rampStep    (rampStep)
   );

   // ---------------------------------------------------------------
   // Avalon-MM handshake
   // ---------------------------------------------------------------
   // Every access takes one wait state: waitrequest drops one edge
   // after the request appears and the access completes on the next.
   assign request     = read | write;
   assign accept      = request & ~waitrequest;
   assign writeAccept = write & ~waitrequest & byteenable[0];
   assign wordIdx     = address[lpd_pkg::ADDR_W-1:2];

   // Wait-state generator
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= ~(request & waitrequest);
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_decode
         assign hitCfg[gi]     = (wordIdx == lpd_pkg::CHAN_IDX[gi]);
         assign hitApplied[gi] = (wordIdx == lpd_pkg::APPLIED_IDX[gi]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read data mux
   // ---------------------------------------------------------------
   // Unmapped words read as zero; the OR chain needs no priority
   // because at most one word matches.
   assign rdTerm[0] = 32'h0000_0000;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_rdmux
         logic [31:0] cfgWord;
         logic [31:0] appWord;
         assign cfgWord = hitCfg[gi] ? {24'h00_0000, cfgReg[gi]} : 32'h0000_0000;
         assign appWord = hitApplied[gi] ? {25'h000_0000, applied[gi]} : 32'h0000_0000;
         assign rdTerm[gi+1] = rdTerm[gi] | cfgWord | appWord;
      end
   endgenerate

   // Read data register, loaded as waitrequest falls
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         readdata <= 32'h0000_0000;
      end else if (read & waitrequest) begin
         readdata <= rdTerm[NCH];
      end
   end

   // ---------------------------------------------------------------
   // Channel drive registers
   // ---------------------------------------------------------------
   // Only byte lane 0 carries data; the applied-duty words are read
   // only and ignore writes.
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_cfg
         always_ff @(posedge core_clk) begin
            if (!reset_n) begin
               cfgReg[gi] <= lpd_pkg::CHAN_RESET;
            end else if (writeAccept && hitCfg[gi]) begin
               cfgReg[gi].rampEnable <= writedata[lpd_pkg::RAMP_BIT];
               cfgReg[gi].dutyCode   <= writedata[lpd_pkg::DUTY_MSB:0];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Per-channel duty ramp
   // ---------------------------------------------------------------
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ramp
         lpd_duty_ramp u_ramp (
            .core_clk    (core_clk),
            .reset_n     (reset_n),
            .cfg         (cfgReg[gi]),
            .periodStart (periodStart),
            .rampStep    (rampStep),
            .applied     (applied[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // PWM compare and pin drive
   // ---------------------------------------------------------------
   // Pin is low for periodCount < applied; full duty never releases,
   // zero never pulls low.
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_pwm
         assign pinOn[gi] = (applied[gi] >= lpd_pkg::DUTY_FULL) |
                            (periodCount < applied[gi]);
      end
   endgenerate

   // Registered pin levels, active low drive
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ledDrive <= '1;
      end else begin
         ledDrive <= ~pinOn;
      end
   end

endmodule

// ---- testbench/lpd_top_checker.sv ----
`timescale 1ns/100ps
module lpd_top_checker (
   input wire logic                            core_clk,
   input wire logic                            reset_n,
   input wire logic                            read,
   input wire logic                            write,
   input wire logic [31:0]                     readdata,
   input wire logic                            waitrequest,
   input wire logic [lpd_pkg::NUM_CHANNELS-1:0] ledDrive
);
   // ----------------------------------------
   // Bus handshake and pin checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_wait_reset: assert property (disable iff (1'b0) !reset_n |=> waitrequest && readdata == 0)
      else $error("bus not idle after reset");
   chk_led_reset: assert property (disable iff (1'b0) !reset_n |=> &ledDrive)
      else $error("pins not dark after reset");
   chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no single wait state");
   chk_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("wait low too long");
   chk_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("answer without request");
   chk_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   chk_read_hold: assert property (!read |=> $stable(readdata))
      else $error("read data moved");
   // Shortest burst is one tick, so any low run under 9 clocks is a glitch
   chk_burst_a: assert property ($fell(ledDrive[0]) |=> !ledDrive[0] [*8])
      else $error("short burst on pin a");
   chk_burst_b: assert property ($fell(ledDrive[1]) |=> !ledDrive[1] [*8])
      else $error("short burst on pin b");
   chk_burst_c: assert property ($fell(ledDrive[2]) |=> !ledDrive[2] [*8])
      else $error("short burst on pin c");
endmodule

// ---- testbench/lpd_led_model.sv ----
`timescale 1ns/100ps
module lpd_led_model (
   input wire logic       core_clk,
   input wire logic       clear,
   input wire logic [2:0] ledDrive,
   output int             lowCnt [3]
);
   // LED lit while its pin is low; clocks lit are summed per window
   always @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         lowCnt[i] <= clear ? 0 : lowCnt[i] + int'(!ledDrive[i]);
      end
   end
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   logic        core_clk;
   logic        reset_n;
   logic [9:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [2:0]  ledDrive;
   logic        clear;
   logic [31:0] q;
   int          lowCnt [3];
   int          errors;
   int          total_checks;
   int          cycles;
   int          e;
   // Codes per row for channels a, b, c
   logic [6:0]  rows [3][3] = '{'{7'h01, 7'h02, 7'h5F}, '{7'h5E, 7'h7F, 7'h32},
                                '{7'h00, 7'h03, 7'h00}};

   // Short ramp timer, trades the 32 ms step for run time
   lpd_top #(.RAMP_TICKS(4)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .ledDrive(ledDrive));
   lpd_led_model i_led (.core_clk(core_clk), .clear(clear), .ledDrive(ledDrive),
      .lowCnt(lowCnt));

   always #4 core_clk = ~core_clk;

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge core_clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   function automatic logic [9:0] adr(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction

   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      core_clk = 0;
      reset_n = 0;
      {read, write, address, writedata, clear} = '0;
      byteenable = 4'h1;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      check(32'(ledDrive), 32'h0000_0007);
      for (int c = 0; c < 3; c++) begin
         bus(0, adr(lpd_pkg::CHAN_IDX[c]), 0);
         check(q, 32'h0000_0000);
      end
      // Table rows: one period to apply, one period measured
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 3; c++) bus(1, adr(lpd_pkg::CHAN_IDX[c]), 32'(rows[r][c]));
         repeat (5940) @(posedge core_clk);
         clear <= 1'b1;
         @(posedge core_clk);
         clear <= 1'b0;
         repeat (5937) @(posedge core_clk);
         for (int c = 0; c < 3; c++) begin
            e = ((rows[r][c] > 95 ? 95 : int'(rows[r][c])) * 125) / 2;
            check(32'(lowCnt[c] >= e - 3 && lowCnt[c] <= e + 3), 32'h0000_0001);
         end
      end
      // Ramp on a, direct on c, writes just after a period start
      @(negedge ledDrive[1]);
      bus(1, adr(lpd_pkg::CHAN_IDX[0]), 32'h0000_0083);
      bus(1, adr(lpd_pkg::CHAN_IDX[2]), 32'h0000_0028);
      repeat (2960) @(posedge core_clk);
      bus(0, adr(lpd_pkg::APPLIED_IDX[2]), 0);
      check(q, 32'h0000_0000);
      for (int k = 1; k < 5; k++) begin
         repeat (5930) @(posedge core_clk);
         bus(0, adr(lpd_pkg::APPLIED_IDX[0]), 0);
         check(q, 32'(k > 3 ? 3 : k));
      end
      bus(0, adr(lpd_pkg::APPLIED_IDX[2]), 0);
      check(q, 32'h0000_0028);
      // Readback, unmapped, read-only and masked byte writes
      bus(0, adr(lpd_pkg::CHAN_IDX[0]), 0);
      check(q, 32'h0000_0083);
      bus(0, 10'h000, 0);
      check(q, 32'h0000_0000);
      bus(1, adr(lpd_pkg::APPLIED_IDX[0]), 32'h0000_007F);
      byteenable <= 4'h0;
      bus(1, adr(lpd_pkg::CHAN_IDX[2]), 32'h0000_0005);
      byteenable <= 4'h1;
      bus(0, adr(lpd_pkg::APPLIED_IDX[0]), 0);
      check(q, 32'h0000_0003);
      bus(0, adr(lpd_pkg::CHAN_IDX[2]), 0);
      check(q, 32'h0000_0028);
      // Ramp down 3 to 1; two periods at least, then it must rest at 1
      bus(1, adr(lpd_pkg::CHAN_IDX[0]), 32'h0000_0081);
      repeat (11880) @(posedge core_clk);
      bus(0, adr(lpd_pkg::APPLIED_IDX[0]), 0);
      check(q, 32'h0000_0001);
      // Reset in mid-run returns pins and registers to idle
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      check(32'(ledDrive), 32'h0000_0007);
      bus(0, adr(lpd_pkg::CHAN_IDX[0]), 0);
      check(q, 32'h0000_0000);
      bus(0, adr(lpd_pkg::APPLIED_IDX[0]), 0);
      check(q, 32'h0000_0000);
      end_sim();
   end
endmodule

bind lpd_top lpd_top_checker i_chk (.core_clk(core_clk), .reset_n(reset_n), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .ledDrive(ledDrive));
